/* File: src/rdci_pkg.sv */
// package: shared constants for the relay driver control link
// assumes: both ends run on clk at 10 MHz, link pins cross domains
package rdci_pkg;
  localparam int unsigned NUM_OUTPUTS  = 8;
  localparam int unsigned ADDR_W       = 3;
  localparam int unsigned CNT_W        = 4;
  localparam logic [7:0]  LATCH_RESET  = 8'h00;
  localparam logic [7:0]  LATCH_ALL_ON = 8'hFF;
  localparam int unsigned WORD_MSB     = 7;
  localparam int unsigned WORD_LSB     = 0;
  // clk period and serial clock half period in ns; the half period rounded up to whole clk cycles
  localparam int unsigned CLK_NS       = 100;
  localparam int unsigned SCLK_HALF_NS = 400;
  localparam int unsigned SCLK_HALF_CY =
    (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  // register map of the controller's own port
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_WORD   = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_ECHO   = 2'h3;
  localparam int unsigned CTRL_GO     = 0;
  localparam int unsigned CTRL_PAR    = 1;
  localparam int unsigned CTRL_SET    = 2;
  localparam int unsigned CTRL_CLR    = 3;
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned WORD_LEVEL  = 3;
  typedef enum logic [3:0] {
    RDCI_IDLE  = 4'b0001,
    RDCI_LOW   = 4'b0010,
    RDCI_HIGH  = 4'b0100,
    RDCI_RAISE = 4'b1000
  } rdci_state_t;
endpackage

/* File: src/rdci_link_if.sv */
// interface: control pins between controller and relay driver
// assumes: single-direction pins only, no tristate needed
interface rdci_link_if;
  logic       cs_n;
  logic       sclk;
  logic       sdi;
  logic       sdo;
  logic [2:0] addr;
  logic       level_select;
  logic       set_n;
  logic       reset_n;
  modport device (
    input  cs_n, sclk, sdi, addr, level_select, set_n, reset_n,
    output sdo
  );
  modport host (
    output cs_n, sclk, sdi, addr, level_select, set_n, reset_n,
    input  sdo
  );
endinterface

/* File: src/rdci_device.sv */
// relay driver control end: serial shift register and parallel update
// assumes: link pins asynchronous to clk, sampled by two flip-flops
// Summary of operation
// - eight-bit shift register, msb drives output eight
// - chip select low: sample data on sclk rise
// - chip select rise copies shift register to latch
// - serial out is last stage, changes on fall
// - words go msb first, in and out
// - outputs hold while chip select low
// - controller raises select after eight bits, or after none when parallel
// - chip select high: clock and data ignored
// - select high: serial out shows word msb
// - register keeps only the last eight bits
// - latch updates regardless of sclk level
// - three address bits select one output
// - level high turns output on, low off
// - select low: address and level ignored
// - select fall captures address, level; rise updates
// - address must be set before select falls
// - set low forces all ones, overrides control
// - reset low clears all, overrides set
// - cascade: shared select, chained serial data
// - shared data line, one select at time
// - latched one pulls output to power ground
module rdci_device (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // link
  rdci_link_if.device     link,
  // variant select: high for parallel loading
  input  wire logic       parallel_mode,
  // relay outputs
  output logic [7:0]      relay_output_q,
  output logic [7:0]      relay_drive_oe_q
);
  logic       cs_s, sclk_s, sdi_s, set_s, rst_s, lvl_s, pm_s;
  logic [2:0] addr_s;
  logic       cs_prev_q, sclk_prev_q;
  logic [7:0] shift_q;
  logic       sdo_q;
  logic [2:0] par_addr_q;
  logic       par_level_q;
  logic       cs_rise, sclk_rise, sclk_fall;

  // each pin through its own two-flop stage; reset values match the
  // idle pin levels, so no false select or clock edge follows reset
  rdci_sync #(.WIDTH(1), .INIT(1'h1)) cs_sync_inst (
    .clk    (clk),
    .reset  (reset),
    .pin    (link.cs_n),
    .sync_q (cs_s)
  );

  rdci_sync #(.WIDTH(1), .INIT(1'h0)) sclk_sync_inst (
    .clk    (clk),
    .reset  (reset),
    .pin    (link.sclk),
    .sync_q (sclk_s)
  );

  rdci_sync #(.WIDTH(1), .INIT(1'h0)) sdi_sync_inst (
    .clk    (clk),
    .reset  (reset),
    .pin    (link.sdi),
    .sync_q (sdi_s)
  );

  rdci_sync #(.WIDTH(1), .INIT(1'h1)) set_sync_inst (
    .clk    (clk),
    .reset  (reset),
    .pin    (link.set_n),
    .sync_q (set_s)
  );

  rdci_sync #(.WIDTH(1), .INIT(1'h1)) rst_sync_inst (
    .clk    (clk),
    .reset  (reset),
    .pin    (link.reset_n),
    .sync_q (rst_s)
  );

  rdci_sync #(.WIDTH(1), .INIT(1'h0)) lvl_sync_inst (
    .clk    (clk),
    .reset  (reset),
    .pin    (link.level_select),
    .sync_q (lvl_s)
  );

  rdci_sync #(.WIDTH(1), .INIT(1'h0)) pm_sync_inst (
    .clk    (clk),
    .reset  (reset),
    .pin    (parallel_mode),
    .sync_q (pm_s)
  );

  // address is quasi-static: it settles before select falls, so
  // a bitwise stage is safe; a mixed value is overwritten in time
  rdci_sync #(.WIDTH(3), .INIT(3'h0)) addr_sync_inst (
    .clk    (clk),
    .reset  (reset),
    .pin    (link.addr),
    .sync_q (addr_s)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_prev_q   <= cs_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign cs_rise   = cs_s & ~cs_prev_q;
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_s;

  // shift register, msb enters first and leaves first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_q <= rdci_pkg::LATCH_RESET;
    end else if (!rst_s) begin
      shift_q <= rdci_pkg::LATCH_RESET;
    end else if (!set_s) begin
      shift_q <= rdci_pkg::LATCH_ALL_ON;
    end else if (sclk_rise && !pm_s) begin
      shift_q <= {shift_q[6:0], sdi_s};
    end
  end

  // serial out: last stage, updated on falling sclk or while idle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sdo_q <= 1'b0;
    end else if (cs_s || sclk_fall) begin
      sdo_q <= shift_q[rdci_pkg::WORD_MSB];
    end
  end
  assign link.sdo = sdo_q;

  // parallel register follows the pins while deselected; the value
  // held at select fall is what the next select rise applies
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      par_addr_q  <= 3'h0;
      par_level_q <= 1'b0;
    end else if (!rst_s) begin
      par_addr_q  <= 3'h0;
      par_level_q <= 1'b0;
    end else if (!set_s) begin
      par_addr_q  <= 3'h7;
      par_level_q <= 1'b1;
    end else if (cs_s) begin
      par_addr_q  <= addr_s;
      par_level_q <= lvl_s;
    end
  end

  // output latch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      relay_output_q <= rdci_pkg::LATCH_RESET;
    end else if (!rst_s) begin
      relay_output_q <= rdci_pkg::LATCH_RESET;
    end else if (!set_s) begin
      relay_output_q <= rdci_pkg::LATCH_ALL_ON;
    end else if (cs_rise) begin
      if (pm_s) begin
        relay_output_q[par_addr_q] <= par_level_q;
      end else begin
        relay_output_q <= shift_q;
      end
    end
  end

  // open-drain drive: enable pulls to power ground when bit is one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      relay_drive_oe_q <= rdci_pkg::LATCH_RESET;
    end else if (!rst_s) begin
      relay_drive_oe_q <= rdci_pkg::LATCH_RESET;
    end else if (!set_s) begin
      relay_drive_oe_q <= rdci_pkg::LATCH_ALL_ON;
    end else if (cs_rise) begin
      if (pm_s) begin
        relay_drive_oe_q[par_addr_q] <= par_level_q;
      end else begin
        relay_drive_oe_q <= shift_q;
      end
    end
  end
endmodule

// two-flop synchroniser for one pin or a quasi-static bus
// the first stage is read by nothing but the second
module rdci_sync #(
  parameter int unsigned      WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // pin and its synchronised copy
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] sync_q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end
endmodule

/* File: src/rdci_host.sv */
// controller end: drives select, serial clock and data from registers
// assumes: software port on clk, sdo pin from device is asynchronous
module rdci_host (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // software port
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata_q,
  // link
  rdci_link_if.host       link
);
  rdci_pkg::rdci_state_t state_q;
  logic [7:0] word_q, echo_q;
  logic [3:0] ctrl_q;
  logic [3:0] bit_q;
  logic [2:0] div_q;
  logic       cs_n_q, sclk_q, sdi_q;
  logic [1:0] sdo_sy;
  logic       go;

  assign go = wr && addr == rdci_pkg::REG_CTRL &&
              wdata[rdci_pkg::CTRL_GO] && state_q == rdci_pkg::RDCI_IDLE;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sdo_sy <= 2'h0;
    end else begin
      sdo_sy <= {sdo_sy[0], link.sdo};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_q <= 8'h00;
      ctrl_q <= 4'h0;
    end else if (wr && state_q == rdci_pkg::RDCI_IDLE) begin
      if (addr == rdci_pkg::REG_WORD) begin
        word_q <= wdata;
      end
      if (addr == rdci_pkg::REG_CTRL) begin
        ctrl_q <= {wdata[3:1], 1'b0};
      end
    end
  end

  // sequencer: cs low, eight sclk periods msb first (none with CTRL_PAR set), then cs high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= rdci_pkg::RDCI_IDLE;
      cs_n_q  <= 1'b1;
      sclk_q  <= 1'b0;
      sdi_q   <= 1'b0;
      bit_q   <= 4'h0;
      div_q   <= 3'h0;
      echo_q  <= 8'h00;
    end else begin
      case (state_q)
        rdci_pkg::RDCI_IDLE: begin
          if (go) begin
            cs_n_q  <= 1'b0; // address already on the pins
            sdi_q   <= word_q[rdci_pkg::WORD_MSB];
            bit_q   <= 4'h0;
            div_q   <= 3'h0;
            state_q <= rdci_pkg::RDCI_LOW;
          end
        end
        rdci_pkg::RDCI_LOW: begin
          if (div_q == 3'(rdci_pkg::SCLK_HALF_CY - 1)) begin
            div_q   <= 3'h0;
            if (ctrl_q[rdci_pkg::CTRL_PAR] || bit_q == 4'h8) begin
              state_q <= rdci_pkg::RDCI_RAISE;
            end else begin
              sclk_q  <= 1'b1;
              state_q <= rdci_pkg::RDCI_HIGH;
            end
          end else begin
            div_q <= div_q + 3'h1;
          end
        end
        rdci_pkg::RDCI_HIGH: begin
          if (div_q == 3'(rdci_pkg::SCLK_HALF_CY - 1)) begin
            div_q   <= 3'h0;
            sclk_q  <= 1'b0;
            echo_q  <= {echo_q[6:0], sdo_sy[1]};
            bit_q   <= bit_q + 4'h1;
            sdi_q   <= word_q[3'(6 - bit_q[2:0])];
            state_q <= rdci_pkg::RDCI_LOW;
          end else begin
            div_q <= div_q + 3'h1;
          end
        end
        rdci_pkg::RDCI_RAISE: begin
          cs_n_q  <= 1'b1;
          state_q <= rdci_pkg::RDCI_IDLE;
        end
        default: state_q <= rdci_pkg::RDCI_IDLE;
      endcase
    end
  end

  assign link.cs_n         = cs_n_q;
  assign link.sclk         = sclk_q;
  assign link.sdi          = sdi_q;
  assign link.addr         = word_q[2:0];
  assign link.level_select = word_q[rdci_pkg::WORD_LEVEL];
  assign link.set_n        = ~ctrl_q[rdci_pkg::CTRL_SET];
  assign link.reset_n      = ~ctrl_q[rdci_pkg::CTRL_CLR];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        rdci_pkg::REG_CTRL:   rdata_q <= {4'h0, ctrl_q};
        rdci_pkg::REG_WORD:   rdata_q <= word_q;
        rdci_pkg::REG_STATUS: rdata_q <= {7'h00,
                                 state_q != rdci_pkg::RDCI_IDLE};
        rdci_pkg::REG_ECHO:   rdata_q <= echo_q;
        default:              rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
endmodule

/* File: tb/rdci_link_chk.sv */
// checker: protocol properties on the link pins
// assumes: placed beside the link interface, one clk domain
module rdci_link_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // link pins
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       sdi,
  input wire logic       sdo,
  input wire logic [2:0] addr,
  input wire logic       level_select,
  input wire logic       set_n,
  input wire logic       reset_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [3:0] rises_q;
  logic       sclk_q;
  // rises per frame, cleared while deselected
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rises_q <= 4'h0;
      sclk_q  <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        rises_q <= 4'h0;
      end else if (sclk && !sclk_q) begin
        rises_q <= rises_q + 4'h1;
      end
    end
  end
  // settle margin covers the device's input synchronizer
  sequence idle_s; (cs_n && set_n && reset_n) [*6]; endsequence
  sequence high_s; sclk [*4] ##1 !sclk; endsequence
  sequence lead_s; (!sclk) [*4]; endsequence
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("sclk moves while deselected");
  bit_count_a: assert property ($rose(cs_n) |->
    (rises_q == 4'h8 || rises_q == 4'h0))
    else $error("frame not eight bits");
  sdo_quiet_a: assert property (idle_s |=> $stable(sdo))
    else $error("sdo moves while deselected");
  sdo_fall_a: assert property (!cs_n && $changed(sdo) |-> !sclk)
    else $error("sdo changed in sclk high");
  sdi_hold_a: assert property ($rose(sclk) |-> $stable(sdi))
    else $error("sdi moves at sclk rise");
  sclk_high_a: assert property ($rose(sclk) |-> high_s)
    else $error("sclk high phase wrong");
  addr_hold_a: assert property (!cs_n && !$past(cs_n) |->
    $stable(addr) && $stable(level_select))
    else $error("address moves in frame");
  lead_in_a: assert property ($fell(cs_n) |-> lead_s)
    else $error("no sclk lead in");
endmodule

/* File: tb/tb_relay_driver_control_interface.sv */
// testbench: host and device joined by the link, driven by software
// assumes: host register map and timing as in the package
module tb_relay_driver_control_interface;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       reset;
  logic       parallel_mode;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata_q;
  logic [7:0] relay_output_q;
  logic [7:0] relay_drive_oe_q;
  logic [7:0] got;
  logic [7:0] want;
  int         failures;
  int         compares;
  int         cycles = 0;
  rdci_link_if link ();
  rdci_device rdci_device_inst (.clk(clk), .reset(reset), .link(link),
    .parallel_mode(parallel_mode), .relay_output_q(relay_output_q),
    .relay_drive_oe_q(relay_drive_oe_q));
  rdci_host rdci_host_inst (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .link(link));
  rdci_link_chk rdci_link_chk_inst (.clk(clk), .reset(reset),
    .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo),
    .addr(link.addr), .level_select(link.level_select),
    .set_n(link.set_n), .reset_n(link.reset_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    got = rdata_q;
  endtask
  // word then go; polls busy so no write is refused
  task automatic send(input logic [7:0] w, input logic [7:0] c);
    int n;
    n = 0;
    wr_reg(rdci_pkg::REG_WORD, w);
    wr_reg(rdci_pkg::REG_CTRL, c);
    if (!c[rdci_pkg::CTRL_PAR]) begin
      repeat (30) @(posedge clk);
      check(relay_output_q, want);
    end
    do begin
      rd_reg(rdci_pkg::REG_STATUS);
      n++;
    end while (got[rdci_pkg::STAT_BUSY] !== 1'b0 && n < 300);
    // a frame that never ends counts against the run
    check({7'h00, got[rdci_pkg::STAT_BUSY]}, 8'h00);
    repeat (8) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    reset = 1'b1;
    parallel_mode = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    failures = 0;
    compares = 0;
    want = 8'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    send(8'hB0, 8'h01);
    want = 8'hB0;
    check(relay_output_q, want);
    check(relay_drive_oe_q, want);
    check({7'h00, link.sdo}, {7'h00, want[7]});
    send(8'h4D, 8'h01);
    want = 8'h4D;
    check(relay_output_q, want);
    rd_reg(rdci_pkg::REG_ECHO);
    check(got, 8'hB0);
    // each address once, level flips the bit either way
    parallel_mode <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      want[i] = ~want[i];
      send({4'h0, want[i], i[2:0]}, 8'h03);
      check(relay_output_q, want);
    end
    wr_reg(rdci_pkg::REG_CTRL, 8'h04);
    repeat (8) @(posedge clk);
    check(relay_output_q, 8'hFF);
    wr_reg(rdci_pkg::REG_CTRL, 8'h0C);
    repeat (8) @(posedge clk);
    check(relay_output_q, 8'h00);
    wr_reg(rdci_pkg::REG_CTRL, 8'h00);
    complete_run();
  end
endmodule
